// File: dv/srw_bench.sv
// Purpose: self-checking bench for the supply reset and watchdog block
// Assumes: shortened counts through top parameters, 100 MHz clock
// Notes:   expected timeouts in the pin-class loop come from the integer model exp_to
`timescale 1ns/1ps
module supervisor_reset_watchdog_bench;
    localparam int RST = 200;
    localparam int SETUP = 15;
    localparam int T_OPEN = 1600;
    localparam int T_PULL = 200;
    localparam int SS = 3;
    localparam int SO = 4;
    localparam int ES = 5;
    localparam int EO = 30;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic supply = 1'b0;
    logic mr_n = 1'b1;
    logic mr_drv = 1'b1;
    logic sel_en = 1'b0;
    logic [1:0] cfg = 2'b00;
    logic kick_en = 1'b0;
    logic [7:0] period = 8'h96;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    wire logic [31:0] wb_rdat;
    wire logic wb_ack;
    wire logic rst_n_d;
    wire logic rst_oe_n;
    wire logic flt_n_d;
    wire logic flt_oe_n;
    wire logic kick;
    // Open-drain reset line with its pull-up
    wire logic rst_line = rst_oe_n ? 1'b1 : rst_n_d;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int rst_low = 0;
    int flt_low = 0;
    logic rl_q = 1'b0;
    logic rl2_q = 1'b0;
    int c_cfg[5] = '{0, 1, 2, 2, 3};
    int c_ext[5] = '{0, 0, 0, 1, 0};

    srw_top #(.RST_CYC_P(34'(RST)), .WD_OPEN_CYC_P(34'(T_OPEN)), .WD_PULL_CYC_P(34'(T_PULL)),
        .INIT_CYC_P(34'h28), .SETUP_CYC_P(34'(SETUP)), .STD_SLOPE_CYC_P(34'(SS)),
        .STD_OFS_CYC_P(34'(SO)), .EXT_SLOPE_CYC_P(34'(ES)), .EXT_OFS_CYC_P(34'(EO))
    ) srw_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply), .manual_reset_in_n_i(mr_n),
        .manual_reset_driven_i(mr_drv), .kick_input_i(kick), .watchdog_enable_select_i(sel_en),
        .timeout_config_pin_i(cfg), .reset_out_n_o(rst_n_d), .reset_out_oe_n_o(rst_oe_n),
        .watchdog_fault_out_n_o(flt_n_d), .watchdog_fault_out_oe_n_o(flt_oe_n),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack)
    );

    srw_host_model srw_host_model_i (
        .clk_i(clk_i), .kick_en_i(kick_en), .period_i(period),
        .sys_reset_n_i(rst_line), .kick_o(kick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Model of the timeout length for each pin class
    function automatic int exp_to(input int c, input int x, input int cap);
        if (c == 1) return T_PULL;
        if (c == 2) return (x != 0) ? ES * cap + EO : SS * cap + SO;
        return T_OPEN;
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic c, input string msg);
        num_checks++;
        if (c !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // Measured count within a small tolerance of the model
    task automatic near(input int n, input int e, input int tol, input string msg);
        chk(n >= e - tol && n <= e + tol, msg);
    endtask

    // Waits for a level on reset (0) or fault (1) enable, bounded
    task automatic wait_pin(input int s, input logic v, input int max, output int n);
        n = 0;
        while (((s == 0) ? rst_oe_n : flt_oe_n) !== v && n < max) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // Classic single cycle; held until ack is sampled, then one idle cycle
    task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_wdat <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_rdat;
        chk(n < 20, "bus ack missing");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Supply dip, new timing pin level and enable, then a full reset delay
    // Enable rises only while reset is held, so no setup window is cut short
    task automatic power_up(input logic [1:0] c);
        int n;
        supply <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(rst_oe_n === 1'b0, "no reset on undervoltage");
        cfg <= c;
        sel_en <= 1'b1;
        supply <= 1'b1;
        @(posedge clk_i);
        wait_pin(0, 1'b1, RST + 60, n);
        near(n, RST + 2, 4, "reset delay after supply");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count, hang limit and reset-time fault monitor
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        rst_low <= rst_low + int'(rst_oe_n === 1'b0);
        flt_low <= flt_low + int'(flt_oe_n === 1'b0);
        rl_q <= (rst_oe_n === 1'b0);
        rl2_q <= rl_q;
        // Two cycles of slack since both outputs are registered
        if (rl2_q && rst_oe_n === 1'b0 && flt_oe_n !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t fault driven in reset", $time);
        end
        if (cyc == 40000) begin
            n_errors++;
            $display("[ERR] %0t run hung", $time);
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        int t0;
        int to;
        int cap;
        int rl;
        logic [31:0] d;
        d = $urandom(32'heab6c0d8);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        supply <= 1'b1;
        @(posedge clk_i);
        chk(rst_n_d === 1'b0 && flt_n_d === 1'b0, "open-drain data not low");
        wait_pin(0, 1'b1, RST + 60, n);
        near(n, RST + 2, 4, "power-up reset delay");
        wb_xfer(1'b0, 4'h0, 32'h0, d);
        chk(d === 32'h0, "ctrl reset value");
        wb_xfer(1'b0, 4'h4, 32'h0, d);
        chk(d === 32'h1, "cap reset value");
        wb_xfer(1'b1, 4'hc, 32'hffffffff, d);
        wb_xfer(1'b0, 4'hc, 32'h0, d);
        chk(d === 32'h0, "unmapped read");
        cap = 8 + int'($urandom % 24);
        wb_xfer(1'b1, 4'h4, 32'(cap), d);
        wb_xfer(1'b0, 4'h4, 32'h0, d);
        chk(d === 32'(cap), "cap readback");
        mr_drv <= 1'b0;
        mr_n <= 1'b0;
        repeat (120) @(posedge clk_i);
        chk(rst_oe_n === 1'b1, "floating manual pin reset");
        mr_drv <= 1'b1;
        mr_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wb_xfer(1'b1, 4'h0, 32'(c_ext[i]), d);
            power_up(2'(c_cfg[i]));
            to = exp_to(c_cfg[i], c_ext[i], cap);
            wait_pin(1, 1'b0, SETUP + to + 60, n);
            near(n, SETUP + to + 2, 4, "timeout length");
            t0 = cyc;
            rl = rst_low;
            wb_xfer(1'b0, 4'h8, 32'h0, d);
            chk(d[1:0] === 2'b10, "status fault flag");
            chk(d[3:2] === 2'(c_cfg[i] % 3), "pin class");
            wait_pin(1, 1'b1, RST + 60, n);
            near(cyc - t0, RST, 4, "fault pulse width");
            chk(rst_low == rl, "reset during fault");
            wait_pin(1, 1'b0, to + 60, n);
            near(n, to + 2, 4, "restart after fault");
            sel_en <= 1'b0;
            repeat (110) @(posedge clk_i);
        end
        period <= 8'(100 + $urandom % 80);
        kick_en <= 1'b1;
        power_up(2'b01);
        n = flt_low;
        repeat (1500) @(posedge clk_i);
        chk(flt_low == n, "fault despite kicks");
        kick_en <= 1'b0;
        wait_pin(1, 1'b0, 400, n);
        chk(n <= T_PULL + 4 && n >= T_PULL - 184, "kicks stopped");
        sel_en <= 1'b0;
        kick_en <= 1'b1;
        repeat (5) @(posedge clk_i);
        n = flt_low;
        repeat (1000) @(posedge clk_i);
        chk(flt_low == n && flt_oe_n === 1'b1, "fault while disabled");
        sel_en <= 1'b1;
        kick_en <= 1'b0;
        wait_pin(1, 1'b0, SETUP + T_PULL + 60, n);
        near(n, SETUP + T_PULL + 2, 4, "timeout after enable");
        mr_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(rst_oe_n === 1'b0, "manual reset");
        repeat (110) @(posedge clk_i);
        chk(flt_oe_n === 1'b1, "fault released in reset");
        mr_n <= 1'b1;
        @(posedge clk_i);
        wait_pin(0, 1'b1, RST + 60, n);
        near(n, RST + 2, 4, "manual release delay");
        wait_pin(1, 1'b0, SETUP + T_PULL + 60, n);
        near(n, SETUP + T_PULL + 2, 4, "watchdog after reset");
        test_done();
    end
endmodule

// File: dv/srw_host_model.sv
// Purpose: host processor model that services the watchdog and obeys system reset
// Assumes: driven on clk_i rising edges; period_i below the shortest timeout
// Notes:   kick idles high, so disabling it never makes a falling edge
`timescale 1ns/1ps
module srw_host_model (
    // Clock
    input wire logic clk_i,
    // Control from the bench
    input wire logic kick_en_i,
    input wire logic [7:0] period_i,
    // System reset line as the host sees it, low holds the host
    input wire logic sys_reset_n_i,
    // Kick pin
    output logic kick_o = 1'b1
);
    int cnt = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Falling edge once per period, low phase 8 cycles so pulses exceed 50 ns
    always @(posedge clk_i) begin
        if (!kick_en_i || !sys_reset_n_i) begin
            cnt <= 0;
            kick_o <= 1'b1;
        end else begin
            cnt <= (cnt + 1 >= int'(period_i)) ? 0 : cnt + 1;
            kick_o <= (cnt >= 8);
        end
    end
endmodule

// File: hdl/srw_pkg.sv
// Purpose: constants, types and timing for the supply reset and watchdog block
// Assumes: 100 MHz clock, classic Wishbone register access
// Notes:   long counts are derived here and overridable as top parameters
package srw_pkg;

    // Clock rate
    localparam int CLK_MHZ = 100;
    localparam int CLK_KHZ = 100000;

    // Times as specified
    localparam int T_RST_MS = 200;
    localparam int T_WD_OPEN_MS = 1600;
    localparam int T_WD_PULL_MS = 200;
    localparam int T_INIT_US = 381;
    localparam int T_SETUP_US = 150;
    localparam int T_HOLD_US = 1;
    localparam int T_KICK_NS = 50;
    localparam int T_WD_DEL_NS = 50;
    // Capacitor slope per 0.1 nF in us, offsets in us
    localparam int T_STD_SLOPE_US = 323;
    localparam int T_STD_OFS_US = 381;
    localparam int T_EXT_SLOPE_US = 7740;
    localparam int T_EXT_OFS_US = 55000;

    // Derived cycle counts
    localparam logic [33:0] RST_CYC = 34'(T_RST_MS * CLK_KHZ);
    localparam logic [33:0] WD_OPEN_CYC = 34'(T_WD_OPEN_MS * CLK_KHZ);
    localparam logic [33:0] WD_PULL_CYC = 34'(T_WD_PULL_MS * CLK_KHZ);
    localparam logic [33:0] INIT_CYC = 34'(T_INIT_US * CLK_MHZ);
    localparam logic [33:0] SETUP_CYC = 34'(T_SETUP_US * CLK_MHZ);
    localparam logic [33:0] STD_SLOPE_CYC = 34'(T_STD_SLOPE_US * CLK_MHZ);
    localparam logic [33:0] STD_OFS_CYC = 34'(T_STD_OFS_US * CLK_MHZ);
    localparam logic [33:0] EXT_SLOPE_CYC = 34'(T_EXT_SLOPE_US * CLK_MHZ);
    localparam logic [33:0] EXT_OFS_CYC = 34'(T_EXT_OFS_US * CLK_MHZ);
    localparam int HOLD_CYC = T_HOLD_US * CLK_MHZ;
    localparam int WD_DEL_CYC = (T_WD_DEL_NS * CLK_MHZ) / 1000;

    // Register byte offsets and reset values
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CAP = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic CTRL_EXT_RST = 1'b0;
    localparam logic [13:0] CAP_RST = 14'h0001;
    localparam int CAP_W = 14;

    // Timing pin classification
    typedef enum logic [1:0] {
        CFG_OPEN = 2'b00,
        CFG_PULL = 2'b01,
        CFG_CAP = 2'b10
    } srw_cfg_e;

    // Reset sequencer
    typedef enum logic [1:0] {
        RS_HOLD = 2'b00,
        RS_DELAY = 2'b01,
        RS_RUN = 2'b10
    } srw_rst_e;

    // Watchdog sequencer
    typedef enum logic [1:0] {
        WD_OFF = 2'b00,
        WD_SETUP = 2'b01,
        WD_RUN = 2'b10,
        WD_FAULT = 2'b11
    } srw_wd_e;

endpackage

// File: hdl/srw_timer.sv
// Purpose: loadable down counter giving a one-cycle done pulse
// Assumes: load value of N yields done exactly N-1 cycles after the load edge
// Notes:   a load while counting restarts the count
`timescale 1ns/1ps
module srw_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic load_i,
    input wire logic [33:0] val_i,
    // Status
    output logic busy_o,
    output logic done_o
);

    logic [33:0] cnt_q;

    // Count down to zero, stop there
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 34'h0;
        end else if (load_i) begin
            cnt_q <= val_i;
        end else if (cnt_q != 34'h0) begin
            cnt_q <= cnt_q - 34'h1;
        end
    end

    // Registered pulse on the last step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= !load_i && (cnt_q == 34'h2);
        end
    end

    assign busy_o = (cnt_q != 34'h0);

endmodule

// File: hdl/srw_top.sv
// Purpose: reset delay and watchdog logic of a supply supervisor
// Assumes: all pin inputs synchronous to clk_i; analog sensing done outside
// Notes:   open-drain outputs are a constant low data bit plus active-low enable
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module srw_top
    import srw_pkg::*;
#(
    parameter logic [33:0] RST_CYC_P = RST_CYC,
    parameter logic [33:0] WD_OPEN_CYC_P = WD_OPEN_CYC,
    parameter logic [33:0] WD_PULL_CYC_P = WD_PULL_CYC,
    parameter logic [33:0] INIT_CYC_P = INIT_CYC,
    parameter logic [33:0] SETUP_CYC_P = SETUP_CYC,
    parameter logic [33:0] STD_SLOPE_CYC_P = STD_SLOPE_CYC,
    parameter logic [33:0] STD_OFS_CYC_P = STD_OFS_CYC,
    parameter logic [33:0] EXT_SLOPE_CYC_P = EXT_SLOPE_CYC,
    parameter logic [33:0] EXT_OFS_CYC_P = EXT_OFS_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Supply comparator, high when above threshold plus hysteresis
    input wire logic supply_ok_i,
    // Manual reset pin and whether anything drives it
    input wire logic manual_reset_in_n_i,
    input wire logic manual_reset_driven_i,
    // Watchdog pins
    input wire logic kick_input_i,
    input wire logic watchdog_enable_select_i,
    input wire logic [1:0] timeout_config_pin_i,
    // Open-drain reset output
    output logic reset_out_n_o,
    output logic reset_out_oe_n_o,
    // Open-drain watchdog fault output
    output logic watchdog_fault_out_n_o,
    output logic watchdog_fault_out_oe_n_o,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    srw_rst_e rs_q, rs_d;
    srw_wd_e wd_q, wd_d;
    srw_cfg_e cfg_q;
    logic mr_eff;
    logic rst_cause;
    logic supply_q;
    logic kick_q;
    logic kick_fall;
    logic kick_ok;
    logic wd_allow;
    logic ext_q;
    logic [13:0] cap_q;
    logic [33:0] limit;
    logic rt_load, rt_busy, rt_done;
    logic wt_load, wt_busy, wt_done;
    logic [33:0] wt_val;
    logic it_load, it_busy, it_done;
    logic wb_req;
    logic [31:0] rd_d;

    // Timeout for the class found on the timing pin
    function automatic logic [33:0] wd_limit(srw_cfg_e c, logic ext,
                                             logic [13:0] cap);
        logic [33:0] t;
        t = 34'h0;
        unique case (c)
            CFG_OPEN: t = WD_OPEN_CYC_P;
            CFG_PULL: t = WD_PULL_CYC_P;
            CFG_CAP: begin
                if (ext) begin
                    t = 34'(EXT_SLOPE_CYC_P * 34'(cap)) + EXT_OFS_CYC_P;
                end else begin
                    t = 34'(STD_SLOPE_CYC_P * 34'(cap)) + STD_OFS_CYC_P;
                end
            end
            default: t = WD_OPEN_CYC_P;
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning

    // Floating pin reads inactive, like the internal pull-up
    assign mr_eff = manual_reset_driven_i ? manual_reset_in_n_i : 1'b1;
    // Level inputs are assumed held for many cycles by the host
    assign rst_cause = !supply_ok_i || !mr_eff;

    // Previous samples for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            supply_q <= 1'b0;
            kick_q <= 1'b1;
        end else begin
            supply_q <= supply_ok_i;
            kick_q <= kick_input_i;
        end
    end

    // Only falling edges count; gated off outside normal running
    assign kick_fall = kick_q && !kick_input_i;
    assign kick_ok = kick_fall && (wd_q == WD_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Timing pin evaluation

    // Restart whenever supply enters the valid region
    assign it_load = supply_ok_i && !supply_q;

    srw_timer u_init_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(it_load),
        .val_i(INIT_CYC_P),
        .busy_o(it_busy),
        .done_o(it_done)
    );

    // Class is taken when the evaluation finishes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= CFG_OPEN;
        end else if (it_done) begin
            unique case (timeout_config_pin_i)
                2'b01: cfg_q <= CFG_PULL;
                2'b10: cfg_q <= CFG_CAP;
                default: cfg_q <= CFG_OPEN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // Hold, then a full delay once every cause has gone
    always_comb begin
        rs_d = rs_q;
        unique case (rs_q)
            RS_HOLD: if (!rst_cause) rs_d = RS_DELAY;
            RS_DELAY: begin
                if (rst_cause) begin
                    rs_d = RS_HOLD;
                end else if (rt_done) begin
                    rs_d = RS_RUN;
                end
            end
            RS_RUN: if (rst_cause) rs_d = RS_HOLD;
            default: rs_d = RS_HOLD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rs_q <= RS_HOLD;
        end else begin
            rs_q <= rs_d;
        end
    end

    // Shared by the reset delay and the fault pulse; they never overlap
    assign rt_load = (rs_q != RS_DELAY && rs_d == RS_DELAY) ||
                     (wd_q != WD_FAULT && wd_d == WD_FAULT);

    srw_timer u_rst_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(rt_load),
        .val_i(RST_CYC_P),
        .busy_o(rt_busy),
        .done_o(rt_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sequencer

    // Runs only with reset released, select high and pin evaluated
    assign wd_allow = (rs_q == RS_RUN) && watchdog_enable_select_i &&
                      !it_busy;
    assign limit = wd_limit(cfg_q, ext_q, cap_q);

    // A disable or reset drops a running fault pulse at once
    always_comb begin
        wd_d = wd_q;
        unique case (wd_q)
            WD_OFF: if (wd_allow) wd_d = WD_SETUP;
            WD_SETUP: begin
                if (!wd_allow) begin
                    wd_d = WD_OFF;
                end else if (wt_done) begin
                    wd_d = WD_RUN;
                end
            end
            WD_RUN: begin
                if (!wd_allow) begin
                    wd_d = WD_OFF;
                end else if (wt_done && !kick_ok) begin
                    wd_d = WD_FAULT;
                end
            end
            WD_FAULT: begin
                if (!wd_allow) begin
                    wd_d = WD_OFF;
                end else if (rt_done) begin
                    wd_d = WD_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_q <= WD_OFF;
        end else begin
            wd_q <= wd_d;
        end
    end

    // Setup window first, then the timeout on each restart
    assign wt_load = (wd_q == WD_OFF && wd_d == WD_SETUP) ||
                     (wd_q != WD_RUN && wd_d == WD_RUN) ||
                     (kick_ok && wd_d == WD_RUN);
    assign wt_val = (wd_d == WD_SETUP) ? SETUP_CYC_P : limit;

    srw_timer u_wd_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(wt_load),
        .val_i(wt_val),
        .busy_o(wt_busy),
        .done_o(wt_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs

    // Driven from next state so the fault pin moves one edge after expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_out_n_o <= 1'b0;
            reset_out_oe_n_o <= 1'b0;
            watchdog_fault_out_n_o <= 1'b0;
            watchdog_fault_out_oe_n_o <= 1'b1;
        end else begin
            reset_out_n_o <= 1'b0;
            reset_out_oe_n_o <= (rs_d == RS_RUN);
            watchdog_fault_out_n_o <= 1'b0;
            watchdog_fault_out_oe_n_o <= (wd_d != WD_FAULT) || (rs_d != RS_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone registers

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Control and capacitor value; byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_q <= CTRL_EXT_RST;
            cap_q <= CAP_RST;
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
                ext_q <= wb_dat_i[0];
            end
            if (wb_adr_i == REG_CAP) begin
                if (wb_sel_i[0]) cap_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) cap_q[13:8] <= wb_dat_i[13:8];
            end
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_d = 32'h0;
        unique case (wb_adr_i)
            REG_CTRL: rd_d = {31'h0, ext_q};
            REG_CAP: rd_d = {18'h0, cap_q};
            REG_STAT: rd_d = {25'h0, wd_q, it_busy, cfg_q,
                              (wd_q == WD_FAULT), (rs_q != RS_RUN)};
            default: rd_d = 32'h0;
        endcase
    end

    // One-cycle answer, every address acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_d : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_uv_asserts: assert property (@(posedge clk_i) disable iff (rst_i)
        !supply_ok_i |=> !reset_out_oe_n_o)
        else $error("reset not asserted on undervoltage");

    a_mr_asserts: assert property (@(posedge clk_i) disable iff (rst_i)
        (manual_reset_driven_i && !manual_reset_in_n_i) |=> !reset_out_oe_n_o)
        else $error("reset not asserted on manual reset");

    a_rst_release: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(reset_out_oe_n_o) |-> $past(rt_done) && $past(rs_q) == RS_DELAY)
        else $error("reset released without full delay");

    a_mr_float: assert property (@(posedge clk_i) disable iff (rst_i)
        (!manual_reset_driven_i && supply_ok_i && rs_q == RS_RUN) |=> rs_q == RS_RUN)
        else $error("floating manual reset asserted reset");

    a_init_start: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(supply_ok_i) |=> it_busy ##1 it_busy)
        else $error("pin evaluation did not start");

    a_limit_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q == CFG_OPEN |-> limit == WD_OPEN_CYC_P)
        else $error("wrong timeout for open timing pin");

    a_cap_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        (cfg_q == CFG_CAP && !ext_q) |->
            limit == 34'(STD_SLOPE_CYC_P * 34'(cap_q)) + STD_OFS_CYC_P)
        else $error("wrong standard capacitor timeout");

    a_sel_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !watchdog_enable_select_i |=> wd_q == WD_OFF)
        else $error("watchdog active while deselected");

    a_setup_ign: assert property (@(posedge clk_i) disable iff (rst_i)
        (wd_q == WD_OFF && wd_d == WD_SETUP) |=> wd_q == WD_SETUP [*2])
        else $error("setup window cut short");

    a_kick_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        kick_ok |-> $past(kick_input_i) && !kick_input_i)
        else $error("kick accepted without falling edge");

    a_fault_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        (wd_q == WD_RUN && wt_done && !kick_ok && wd_allow && !rst_cause)
            |=> !watchdog_fault_out_oe_n_o)
        else $error("fault not raised on timeout");

    a_fault_norst: assert property (@(posedge clk_i) disable iff (rst_i)
        !watchdog_fault_out_oe_n_o |-> reset_out_oe_n_o)
        else $error("fault and reset asserted together");

    a_rst_wdoff: assert property (@(posedge clk_i) disable iff (rst_i)
        rs_q != RS_RUN |=> wd_q == WD_OFF && !kick_ok)
        else $error("watchdog active during reset");

    a_kick_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        (kick_ok && wd_allow) |-> wt_load && wt_val == limit)
        else $error("kick did not restart timeout");

endmodule
